// File: src/mfm_fault_mgr.sv
// How it works
// - Faults split into safety and critical classes
// - Stop-mode safety faults clear without enable cycling
// - Disable-mode safety faults latch until enable cycle
// - Any critical fault removes motor power
// - Critical clears after condition gone and cycle
// - Positive limit blocks positive travel only
// - Positive limit clears: input off, negative motion
// - Negative limit mirrors positive limit handling
// - Position error needs encoder, compares abs difference
// - Position error: next move or cycle clears
// - Below full force: hold, no position error
// - Software stop fault while stop input high
// - Software stop clears: input low, new move
// - No motion while software stop fault stands
// - Over-temperature above limit is critical
// - Over-current, over-voltage, under-voltage are critical
// - Flash error: power-up check or driver link
// - Watchdog timeout when firmware misses service
// - Red solid on critical, blinking on safety
// - Start ignored when enable low or stop high
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mfm_fault_mgr #(
  parameter int BLINK_CYC = mfm_pkg::BLINK_HALF_CYC,
  parameter int WDOG_RST_CYC = mfm_pkg::WDOG_RST_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Controller inputs
  input wire logic enable_i,
  input wire logic sw_stop_i,
  input wire logic start_i,
  // Motion feedback
  input wire logic lim_pos_i,
  input wire logic lim_neg_i,
  input wire logic step_pos_i,
  input wire logic step_neg_i,
  input wire logic moving_i,
  input wire logic force_full_i,
  input wire logic [31:0] enc_pos_i,
  input wire logic [31:0] cmd_pos_i,
  // Condition sensing
  input wire logic over_current_i,
  input wire logic [7:0] temp_c_i,
  input wire logic over_volt_i,
  input wire logic under_volt_i,
  input wire logic boot_check_i,
  input wire logic csum_err_i,
  input wire logic fw_mismatch_i,
  input wire logic drv_link_fail_i,
  // Motion control outputs
  output logic motor_power_o,
  output logic allow_pos_o,
  output logic allow_neg_o,
  output logic start_o,
  output logic hold_o,
  output logic led_red_o,
  output logic led_green_o
);

  // Absolute difference of two signed positions
  function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] d;
    d = a - b;
    abs_diff = d[31] ? (~d + 32'h0000_0001) : d;
  endfunction : abs_diff

  logic [31:0] ctrl_q;
  logic [31:0] perr_lim_q;
  logic [31:0] wdog_lim_q;
  logic [31:0] wdog_cnt_q;
  logic [31:0] hrdata_q;
  logic [31:0] blink_cnt_q;
  logic blink_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic en_prev_q;
  localparam int NUM_SF_W = mfm_pkg::NUM_SF;
  localparam int NUM_CF_W = mfm_pkg::NUM_CF;
  logic [NUM_SF_W-1:0] sf_q;
  logic [NUM_CF_W-1:0] cf_q;

  logic acc;
  logic sw_enable_cmd;
  logic wdog_kick;
  logic en_rise;
  logic clr_ev;
  logic move_req;
  logic perr_over;
  logic [NUM_SF_W-1:0] sf_en;
  logic [NUM_SF_W-1:0] sf_dis;
  logic [NUM_SF_W-1:0] sf_cond;
  logic [NUM_SF_W-1:0] sf_clr;
  logic [NUM_CF_W-1:0] cf_cond;
  logic [31:0] stat_word;
  logic [31:0] rd_word;

  // Bus address phase and command strobes in the write data phase
  assign acc = hsel_i & htrans_i[1] & hready_i;
  assign sw_enable_cmd = wr_pend_q & (wr_addr_q == mfm_pkg::ADDR_CMD)
                         & hwdata_i[mfm_pkg::CMD_ENABLE_BIT];
  assign wdog_kick = wr_pend_q & (wr_addr_q == mfm_pkg::ADDR_CMD)
                     & hwdata_i[mfm_pkg::CMD_KICK_BIT];
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_q;

  // Capture address of a write for its data phase
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= acc & hwrite_i;
      wr_addr_q <= haddr_i[7:0];
    end
  end

  // Register writes; decoded from the low 8 address bits only
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= mfm_pkg::CTRL_RST;
      perr_lim_q <= mfm_pkg::PERR_RST;
      wdog_lim_q <= 32'(WDOG_RST_CYC);
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        mfm_pkg::ADDR_CTRL: ctrl_q <= hwdata_i;
        mfm_pkg::ADDR_PERR: perr_lim_q <= hwdata_i;
        mfm_pkg::ADDR_WDOG: wdog_lim_q <= hwdata_i;
        default: ;
      endcase
    end
  end

  // Status word and read mux
  assign stat_word = {14'h0000, hold_o, motor_power_o, 2'h0, cf_q, 4'h0, sf_q};
  always_comb begin
    case (haddr_i[7:0])
      mfm_pkg::ADDR_CTRL: rd_word = ctrl_q;
      mfm_pkg::ADDR_PERR: rd_word = perr_lim_q;
      mfm_pkg::ADDR_WDOG: rd_word = wdog_lim_q;
      mfm_pkg::ADDR_STAT: rd_word = stat_word;
      default: rd_word = 32'h0000_0000;
    endcase
    if (haddr_i[31:8] != 24'h00_0000) begin
      rd_word = 32'h0000_0000;
    end
  end

  // Read data registered at address phase, shown in data phase
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hrdata_q <= 32'h0000_0000;
    end else if (acc & ~hwrite_i) begin
      hrdata_q <= rd_word;
    end
  end

  // Enable cycle detect: a sampled low then a sampled high
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_prev_q <= 1'b1;
    end else begin
      en_prev_q <= enable_i;
    end
  end
  assign en_rise = enable_i & ~en_prev_q;
  assign clr_ev = en_rise | sw_enable_cmd;

  // Start gating on the controller inputs
  assign move_req = start_i & enable_i & ~sw_stop_i;

  // Safety fault configuration fields
  assign sf_en = ctrl_q[mfm_pkg::CTRL_EN_LSB +: NUM_SF_W];
  assign sf_dis = ctrl_q[mfm_pkg::CTRL_RESP_LSB +: NUM_SF_W];

  // Position error compare, encoder required; hold below full force
  assign perr_over = ctrl_q[mfm_pkg::CTRL_ENC_BIT]
                     & (abs_diff(enc_pos_i, cmd_pos_i) > perr_lim_q);
  assign hold_o = perr_over & ~force_full_i;

  // Safety fault conditions
  always_comb begin
    sf_cond = '0;
    sf_cond[mfm_pkg::SF_PLIM] = sf_en[mfm_pkg::SF_PLIM] & lim_pos_i;
    sf_cond[mfm_pkg::SF_NLIM] = sf_en[mfm_pkg::SF_NLIM] & lim_neg_i;
    sf_cond[mfm_pkg::SF_PERR] = sf_en[mfm_pkg::SF_PERR] & perr_over & force_full_i;
    sf_cond[mfm_pkg::SF_SSTOP] = sf_en[mfm_pkg::SF_SSTOP]
                                 & ctrl_q[mfm_pkg::CTRL_SSIN_BIT] & sw_stop_i;
  end

  // Safety fault clear terms, by response setting
  always_comb begin
    sf_clr = '0;
    sf_clr[mfm_pkg::SF_PLIM] = ~lim_pos_i & step_neg_i;
    sf_clr[mfm_pkg::SF_NLIM] = ~lim_neg_i & step_pos_i;
    sf_clr[mfm_pkg::SF_PERR] = move_req;
    sf_clr[mfm_pkg::SF_SSTOP] = ~sw_stop_i & move_req;
    for (int i = 0; i < NUM_SF_W; i++) begin
      if (sf_dis[i]) begin
        sf_clr[i] = clr_ev;
      end
      if (!sf_en[i]) begin
        sf_clr[i] = 1'b1;
      end
    end
  end

  // Safety fault latches; a present condition wins over a clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sf_q <= '0;
    end else begin
      sf_q <= sf_cond | (sf_q & ~sf_clr);
    end
  end

  // Watchdog counter, restarted by each firmware service
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wdog_cnt_q <= 32'h0000_0000;
    end else if (wdog_kick) begin
      wdog_cnt_q <= 32'h0000_0000;
    end else if (wdog_cnt_q < wdog_lim_q) begin
      wdog_cnt_q <= wdog_cnt_q + 32'h0000_0001;
    end
  end

  // Critical fault conditions
  always_comb begin
    cf_cond = '0;
    cf_cond[mfm_pkg::CF_OC] = over_current_i;
    cf_cond[mfm_pkg::CF_OT] = temp_c_i > mfm_pkg::TEMP_MAX_C;
    cf_cond[mfm_pkg::CF_OV] = over_volt_i;
    cf_cond[mfm_pkg::CF_UV] = under_volt_i;
    cf_cond[mfm_pkg::CF_FLASH] = (boot_check_i & (csum_err_i | fw_mismatch_i))
                                 | (moving_i & drv_link_fail_i);
    cf_cond[mfm_pkg::CF_WDOG] = ~wdog_kick & (wdog_cnt_q >= wdog_lim_q);
  end

  // Critical latches clear only by an enable cycle with condition gone
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cf_q <= '0;
    end else begin
      cf_q <= cf_cond | (cf_q & ~{NUM_CF_W{clr_ev}});
    end
  end

  // Motor power and direction permits
  assign motor_power_o = enable_i & ~(|cf_q) & ~(|(sf_q & sf_dis));
  assign allow_pos_o = motor_power_o & ~sf_q[mfm_pkg::SF_PLIM]
                       & ~sf_q[mfm_pkg::SF_PERR] & ~sf_q[mfm_pkg::SF_SSTOP];
  assign allow_neg_o = motor_power_o & ~sf_q[mfm_pkg::SF_NLIM]
                       & ~sf_q[mfm_pkg::SF_PERR] & ~sf_q[mfm_pkg::SF_SSTOP];
  assign start_o = move_req & motor_power_o & ~sf_q[mfm_pkg::SF_SSTOP];

  // Blink timebase for the red indicator
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      blink_cnt_q <= 32'h0000_0000;
      blink_q <= 1'b0;
    end else if (blink_cnt_q >= 32'(BLINK_CYC - 1)) begin
      blink_cnt_q <= 32'h0000_0000;
      blink_q <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end
  end

  // Indicators: solid red wins over blinking red
  assign led_red_o = (|cf_q) | ((|sf_q) & blink_q);
  assign led_green_o = motor_power_o;

  // Checks
  crit_power_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (|cf_cond) |=> !motor_power_o)
    else $error("critical fault left motor powered");

  crit_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $fell(|cf_q) |-> $past(clr_ev) && !$past(|cf_cond))
    else $error("critical fault cleared without enable cycle");

  en_cycle_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    en_rise |-> $past(enable_i) == 1'b0 && enable_i)
    else $error("enable cycle without prior low");

  plim_block_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sf_q[mfm_pkg::SF_PLIM] |-> !allow_pos_o)
    else $error("positive travel allowed at limit");

  plim_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $fell(sf_q[mfm_pkg::SF_PLIM]) && !$past(sf_dis[mfm_pkg::SF_PLIM])
    && $past(sf_en[mfm_pkg::SF_PLIM])
    |-> $past(!lim_pos_i && step_neg_i))
    else $error("positive limit cleared early");

  nlim_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $fell(sf_q[mfm_pkg::SF_NLIM]) && !$past(sf_dis[mfm_pkg::SF_NLIM])
    && $past(sf_en[mfm_pkg::SF_NLIM])
    |-> $past(!lim_neg_i && step_pos_i))
    else $error("negative limit cleared early");

  perr_push_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(sf_q[mfm_pkg::SF_PERR]) |-> $past(force_full_i))
    else $error("position error raised below full force");

  dis_latch_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $fell(sf_q[mfm_pkg::SF_PERR]) && $past(sf_dis[mfm_pkg::SF_PERR])
    && $past(sf_en[mfm_pkg::SF_PERR]) |-> $past(clr_ev))
    else $error("disable-mode fault cleared without cycle");

  sstop_block_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sf_q[mfm_pkg::SF_SSTOP] |-> !start_o && !allow_pos_o && !allow_neg_o)
    else $error("motion allowed during software stop");

  start_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    start_o |-> enable_i && !sw_stop_i)
    else $error("start passed with enable low or stop high");

  over_temp_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (temp_c_i > mfm_pkg::TEMP_MAX_C) |=> cf_q[mfm_pkg::CF_OT] && !motor_power_o)
    else $error("over-temperature not latched");

  red_led_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (|cf_q) |-> led_red_o)
    else $error("red indicator not solid on critical fault");

  nlim_block_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sf_q[mfm_pkg::SF_NLIM] |-> !allow_neg_o)
    else $error("negative travel allowed at limit");

  dis_power_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (|(sf_q & sf_dis)) |-> !motor_power_o)
    else $error("disable-mode fault left motor powered");

  crit_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (|cf_q) && !clr_ev |=> (|cf_q))
    else $error("critical fault dropped without clear");

  sstop_raise_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sf_en[mfm_pkg::SF_SSTOP] && ctrl_q[mfm_pkg::CTRL_SSIN_BIT] && sw_stop_i
    |=> sf_q[mfm_pkg::SF_SSTOP])
    else $error("software stop fault not raised");

  perr_raise_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ctrl_q[mfm_pkg::CTRL_ENC_BIT] && sf_en[mfm_pkg::SF_PERR] && force_full_i
    && (abs_diff(enc_pos_i, cmd_pos_i) > perr_lim_q) |=> sf_q[mfm_pkg::SF_PERR])
    else $error("position error not raised");

  wdog_fault_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !wdog_kick && (wdog_cnt_q >= wdog_lim_q) |=> cf_q[mfm_pkg::CF_WDOG])
    else $error("watchdog timeout not latched");

  flash_run_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    moving_i && drv_link_fail_i |=> cf_q[mfm_pkg::CF_FLASH])
    else $error("driver link failure not latched");

  stop_auto_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sf_q[mfm_pkg::SF_PLIM] && sf_en[mfm_pkg::SF_PLIM] && !sf_dis[mfm_pkg::SF_PLIM]
    && !lim_pos_i && step_neg_i |=> !sf_q[mfm_pkg::SF_PLIM])
    else $error("stop-mode limit fault not cleared");

  sstop_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sf_q[mfm_pkg::SF_SSTOP] && sf_en[mfm_pkg::SF_SSTOP] && !sf_dis[mfm_pkg::SF_SSTOP]
    && !sw_stop_i && move_req |=> !sf_q[mfm_pkg::SF_SSTOP])
    else $error("software stop fault not cleared by move");

endmodule : mfm_fault_mgr
`default_nettype wire

// File: src/mfm_pkg.sv
`default_nettype none
package mfm_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERR = 8'h04;
  localparam logic [7:0] ADDR_WDOG = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_CMD = 8'h10;
  // Safety fault indices
  localparam int SF_PLIM = 0;
  localparam int SF_NLIM = 1;
  localparam int SF_PERR = 2;
  localparam int SF_SSTOP = 3;
  localparam int NUM_SF = 4;
  // Critical fault indices
  localparam int CF_OC = 0;
  localparam int CF_OT = 1;
  localparam int CF_OV = 2;
  localparam int CF_UV = 3;
  localparam int CF_FLASH = 4;
  localparam int CF_WDOG = 5;
  localparam int NUM_CF = 6;
  // Control register fields
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_RESP_LSB = 8;
  localparam int CTRL_ENC_BIT = 16;
  localparam int CTRL_SSIN_BIT = 17;
  // Command register fields
  localparam int CMD_ENABLE_BIT = 0;
  localparam int CMD_KICK_BIT = 1;
  // Status register fields
  localparam int STAT_SF_LSB = 0;
  localparam int STAT_CF_LSB = 8;
  localparam int STAT_PWR_BIT = 16;
  localparam int STAT_HOLD_BIT = 17;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PERR_RST = 32'h0000_0100;
  // Temperature limit in degrees C (75)
  localparam logic [7:0] TEMP_MAX_C = 8'h4B;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WDOG_RST_MS = 100;
  localparam int WDOG_RST_CYC = WDOG_RST_MS * 1000000 / CLK_PERIOD_NS;
endpackage : mfm_pkg
`default_nettype wire

// File: dv/mfm_plc.sv
`timescale 1ns/1ps
`default_nettype none
module mfm_plc (
  input wire logic clk_i,
  output logic enable_o,
  output logic sw_stop_o
);
  // Idle levels: controller enabled, no stop request
  initial begin
    enable_o = 1'h1;
    sw_stop_o = 1'h0;
  end
  // Enable low for n edges, then high again, to clear latched faults
  task automatic cycle(input int n);
    @(posedge clk_i);
    enable_o <= 1'h0;
    repeat (n) @(posedge clk_i);
    enable_o <= 1'h1;
    repeat (2) @(posedge clk_i);
  endtask : cycle
  // Plain enable level
  task automatic en(input logic v);
    @(posedge clk_i);
    enable_o <= v;
  endtask : en
  // Stop input level
  task automatic stop(input logic v);
    @(posedge clk_i);
    sw_stop_o <= v;
  endtask : stop
endmodule : mfm_plc
`default_nettype wire

// File: dv/tb_motion_fault_manager.sv
`timescale 1ns/1ps
`default_nettype none
module tb_motion_fault_manager;
  logic clk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, enc = '0, cmd = '0, q, d, lf = 32'h0000_3C2D;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0, start = 1'h0, lp = 1'h0, ln = 1'h0, sp = 1'h0, sn = 1'h0, mv = 1'h0;
  logic ff = 1'h1, oc = 1'h0, ov = 1'h0, uv = 1'h0, bt = 1'h0, cs = 1'h0, fw = 1'h0, lk = 1'h0;
  logic hro, hresp, en, stp, g, r, pwr, apos, aneg, so, hold, red, green;
  logic [7:0] temp = 8'h19, t;
  int error_cnt = 0, num_checks = 0, n;

  // Clock of 10 ns
  always #5 clk_i = ~clk_i;

  mfm_plc plc (.clk_i(clk_i), .enable_o(en), .sw_stop_o(stp));

  mfm_fault_mgr #(.BLINK_CYC(4), .WDOG_RST_CYC(100000)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hro),
    .hrdata_o(hrdata), .hreadyout_o(hro), .hresp_o(hresp), .enable_i(en),
    .sw_stop_i(stp), .start_i(start), .lim_pos_i(lp), .lim_neg_i(ln), .step_pos_i(sp),
    .step_neg_i(sn), .moving_i(mv), .force_full_i(ff), .enc_pos_i(enc), .cmd_pos_i(cmd),
    .over_current_i(oc), .temp_c_i(temp), .over_volt_i(ov), .under_volt_i(uv),
    .boot_check_i(bt), .csum_err_i(cs), .fw_mismatch_i(fw), .drv_link_fail_i(lk),
    .motor_power_o(pwr), .allow_pos_o(apos), .allow_neg_o(aneg), .start_o(so),
    .hold_o(hold), .led_red_o(red), .led_green_o(green));

  // Counts and verdict
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx

  function automatic logic hot(input logic [7:0] v);
    return v > mfm_pkg::TEMP_MAX_C;
  endfunction : hot

  task automatic ck(input int k);
    repeat (k) @(posedge clk_i);
  endtask : ck

  // Wait for hready, bounded
  task automatic hs;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hro !== 1'h1 && n < 64);
    if (n >= 64) begin
      error_cnt++;
      finish_test();
    end
  endtask : hs

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    haddr <= {24'h0, a};
    hwrite <= 1'h1;
    hsel <= 1'h1;
    hsize <= 3'h2;
    htrans <= 2'h2;
    hs();
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= v;
    hs();
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    haddr <= {24'h0, a};
    hwrite <= 1'h0;
    hsel <= 1'h1;
    hsize <= 3'h2;
    htrans <= 2'h2;
    hs();
    htrans <= 2'h0;
    hsel <= 1'h0;
    hs();
    q = hrdata;
    chk(nm, e, q);
    chk("hresp", 32'h0, hresp);
  endtask : rdc

  // One start pulse; forwarded value seen in its cycle
  task automatic go;
    start <= 1'h1;
    ck(1);
    g = so;
    start <= 1'h0;
    ck(1);
  endtask : go

  task automatic setc(input logic [6:0] c);
    oc <= c[0];
    temp <= c[1] ? 8'h4C : 8'h19;
    ov <= c[2];
    uv <= c[3];
    bt <= c[4] | c[5];
    cs <= c[4];
    fw <= c[5];
    mv <= c[6];
    lk <= c[6];
  endtask : setc

  // Limit hit, release, then travel the other way
  task automatic lim_test(input logic ng);
    lp <= !ng;
    ln <= ng;
    ck(2);
    chk("blocked", 32'h0, ng ? aneg : apos);
    chk("other", 32'h1, ng ? apos : aneg);
    chk("power", 32'h1, pwr);
    r = red;
    n = 0;
    repeat (12) begin
      ck(1);
      if (red !== r) n++;
      r = red;
    end
    chk("blink", 32'h1, n >= 2);
    lp <= 1'h0;
    ln <= 1'h0;
    ck(2);
    chk("held", 32'h0, ng ? aneg : apos);
    sn <= !ng;
    sp <= ng;
    ck(1);
    sn <= 1'h0;
    sp <= 1'h0;
    ck(2);
    chk("freed", 32'h1, ng ? aneg : apos);
  endtask : lim_test

  // Hang guard
  initial begin
    ck(20000);
    error_cnt++;
    finish_test();
  end

  // Main sequence
  initial begin
    ck(3);
    rstn_i <= 1'h1;
    ck(1);
    rdc(mfm_pkg::ADDR_CTRL, mfm_pkg::CTRL_RST, "ctrl");
    rdc(mfm_pkg::ADDR_PERR, mfm_pkg::PERR_RST, "perr");
    rdc(8'h20, 32'h0, "unmapped");
    rdc(mfm_pkg::ADDR_CMD, 32'h0, "cmd");
    wr(mfm_pkg::ADDR_STAT, 32'hFFFF_FFFF);
    rdc(mfm_pkg::ADDR_STAT, 32'h1_0000, "stat");
    wr(mfm_pkg::ADDR_WDOG, 32'hFFFF_FFFF);
    $display("registers done");
    for (int k = 0; k < 7; k++) begin
      setc(7'(32'h1 << k));
      plc.cycle(k % 2 ? 3 : 1);
      chk("power", 32'h0, pwr);
      chk("red", 32'h1, red);
      chk("green", 32'h0, green);
      setc(7'h0);
      rdc(mfm_pkg::ADDR_STAT, 32'h100 << (k < 4 ? k : 4), "crit");
      plc.cycle(1);
      rdc(mfm_pkg::ADDR_STAT, 32'h1_0000, "cleared");
    end
    for (int i = 0; i < 8; i++) begin
      lf = nx(lf);
      t = i == 0 ? 8'h4B : i == 1 ? 8'h4C : lf[7:0];
      temp <= t;
      cs <= lf[8];
      fw <= lf[9];
      lk <= lf[10];
      ck(2);
      temp <= 8'h19;
      rdc(mfm_pkg::ADDR_STAT, hot(t) ? 32'h200 : 32'h1_0000, "temp");
      plc.cycle(1);
    end
    wr(mfm_pkg::ADDR_CMD, 32'h2);
    wr(mfm_pkg::ADDR_WDOG, 32'h28);
    repeat (10) wr(mfm_pkg::ADDR_CMD, 32'h2);
    rdc(mfm_pkg::ADDR_STAT, 32'h1_0000, "kicked");
    ck(60);
    rdc(mfm_pkg::ADDR_STAT, 32'h2000, "wdog");
    wr(mfm_pkg::ADDR_WDOG, 32'hFFFF_FFFF);
    wr(mfm_pkg::ADDR_CMD, 32'h1);
    rdc(mfm_pkg::ADDR_STAT, 32'h1_0000, "sw enable");
    $display("critical done");
    wr(mfm_pkg::ADDR_CTRL, 32'h0003_000F);
    lim_test(1'h0);
    lim_test(1'h1);
    wr(mfm_pkg::ADDR_CTRL, 32'h0003_010F);
    lp <= 1'h1;
    ck(2);
    lp <= 1'h0;
    sn <= 1'h1;
    chk("latch", 32'h0, pwr);
    ck(1);
    sn <= 1'h0;
    ck(2);
    chk("latch", 32'h0, pwr);
    plc.cycle(3);
    chk("power", 32'h1, pwr);
    wr(mfm_pkg::ADDR_CTRL, 32'h0003_000F);
    $display("limits done");
    plc.stop(1'h1);
    ck(2);
    rdc(mfm_pkg::ADDR_STAT, 32'h1_0008, "sstop");
    go();
    chk("start", 32'h0, g);
    plc.stop(1'h0);
    ck(2);
    go();
    chk("start", 32'h0, g);
    go();
    chk("start", 32'h1, g);
    plc.en(1'h0);
    go();
    chk("start", 32'h0, g);
    plc.en(1'h1);
    $display("stop done");
    for (int i = 0; i < 6; i++) begin
      lf = nx(lf);
      d = i == 0 ? 32'h100 : i == 1 ? 32'h101 : {22'h0, lf[9:0]};
      cmd <= lf;
      enc <= lf[10] ? lf - d : lf + d;
      ck(2);
      rdc(mfm_pkg::ADDR_STAT, d > 32'h100 ? 32'h1_0004 : 32'h1_0000, "perr");
      enc <= lf;
      go();
      rdc(mfm_pkg::ADDR_STAT, 32'h1_0000, "perr clr");
    end
    wr(mfm_pkg::ADDR_CTRL, 32'h0003_040F);
    enc <= lf + 32'h200;
    ck(2);
    enc <= lf;
    go();
    rdc(mfm_pkg::ADDR_STAT, 32'h4, "perr latch");
    plc.cycle(1);
    rdc(mfm_pkg::ADDR_STAT, 32'h1_0000, "perr freed");
    ff <= 1'h0;
    enc <= lf + 32'h200;
    ck(2);
    chk("hold", 32'h1, hold);
    rdc(mfm_pkg::ADDR_STAT, 32'h3_0000, "push");
    $display("position done");
    finish_test();
  end
endmodule : tb_motion_fault_manager
`default_nettype wire
